// [fetctl_defines.svh]
/*
  Offsets, field positions, reset values and fixed levels of the protection switch controller.
  Assumes byte addressing on a 32-bit Avalon-MM slave; included by bare name.
*/
//
// Functional notes
// [R01] Series: big discharge turns charge switch on
// [R02] Discharge back in range: charge switch re-blocked
// [R03] Series: big charge turns discharge switch on
// [R04] Charge back in range: discharge switch re-blocked
// [R05] Parallel configuration disables body-diode overrides
// [R06] Low minimum cell charges through precharge switch
// [R07] Discharge turn-on starts with predischarge switch
// [R08] Latched discharge fault, switch off: run load detect
// [R09] Pulse load source, recover only above 4 V
// [R10] Source alternates on/off until recovery or timeout
// [R11] Standalone: faults steer and recover switches autonomously
// [R12] Manual mode: faults only flagged, host disables
// [R13] Off inputs block switches until nothing blocks
// [R14] Current is signed, negative means discharge
`ifndef FETCTL_DEFINES_SVH
`define FETCTL_DEFINES_SVH

`define OFS_CTRL 8'h00
`define OFS_TH_CHG 8'h04
`define OFS_TH_DSG 8'h08
`define OFS_TH_PRECHARGE_SWITCH 8'h0c
`define OFS_PREDISCHARGE_SWITCH_TIME 8'h10
`define OFS_LD_ON 8'h14
`define OFS_LD_OFF 8'h18
`define OFS_LD_TMO 8'h1c
`define OFS_STATUS 8'h20
`define OFS_INT_ST 8'h24
`define OFS_INT_EN 8'h28
`define OFS_INT_CLR 8'h2c

`define CTRL_PARALLEL 0
`define CTRL_MANUAL 1
`define CTRL_PRECHARGE_SWITCH_EN 2
`define CTRL_PREDISCHARGE_SWITCH_EN 3
`define CTRL_LD_EN 4
`define CTRL_HOST_COFF 5
`define CTRL_HOST_DOFF 6

`define INT_CHG_BD 0
`define INT_DSG_BD 1
`define INT_LATCH 2
`define INT_LD_REC 3
`define INT_LD_TMO 4
`define INT_CHG_FLT 5
`define INT_DSG_FLT 6

`define CTRL_RST 8'h00
`define TH_CHG_RST 16'h0064
`define TH_DSG_RST 16'h0064
`define TH_PRECHARGE_SWITCH_RST 16'h0a8c
`define PREDISCHARGE_SWITCH_TIME_RST 16'h0100
`define LD_ON_RST 16'h0040
`define LD_OFF_RST 16'h0400
`define LD_TMO_RST 32'h0010_0000

// Load-sense recovery level in mV
`define LD_LEVEL_MV 16'd4000

`endif

// [fetctl_pkg.sv]
/*
  Types shared by the protection switch controller and its load-detect sequencer.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package fetctl_pkg;

  typedef enum logic [1:0] {DSG_OFF, DSG_PRE, DSG_ON} dsg_state_e;
  typedef enum logic [1:0] {LD_IDLE, LD_SRC_ON, LD_SRC_OFF, LD_DONE} ld_state_e;

  typedef struct packed {
    ld_state_e st;
    logic [15:0] cnt;
    logic [31:0] tmo;
    logic src;
    logic rec;
    logic expired;
  } ld_s;

  typedef struct packed {
    logic coff_s1;
    logic coff_s2;
    logic doff_s1;
    logic doff_s2;
    logic ack;
    logic [31:0] rdata;
    logic [7:0] ctrl;
    logic [15:0] th_chg;
    logic [15:0] th_dsg;
    logic [15:0] th_precharge_switch;
    logic [15:0] predischarge_switch_time;
    logic [15:0] ld_on;
    logic [15:0] ld_off;
    logic [31:0] ld_tmo;
    logic [7:0] int_st;
    logic [7:0] int_en;
    logic latched;
    dsg_state_e dsg_st;
    logic [15:0] predischarge_switch_cnt;
    logic chg_bd;
    logic dsg_bd;
    logic chg_out;
    logic dsg_out;
    logic precharge_switch_out;
    logic predischarge_switch_out;
    logic irq;
  } ctl_s;

endpackage

// [load_detect.sv]
/*
  Load-detect sequencer: pulses the load-sense current source and recovers on a high pin level.
  Assumes arm from same-clock logic and a load-sense reading in mV on the same clock.
*/
`timescale 1ns/1ns
`include "fetctl_defines.svh"
module load_detect (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Control
  input wire logic arm,
  input wire logic [15:0] ld_on,
  input wire logic [15:0] ld_off,
  input wire logic [31:0] ld_tmo,
  input wire logic [15:0] load_sense_mv,
  // Results
  output logic source_en,
  output logic recovered,
  output logic timed_out
);
  fetctl_pkg::ld_s q, d;
  logic [15:0] cnt_nxt;
  logic [31:0] tmo_nxt;

  assign cnt_nxt = q.cnt + 16'h0001;
  assign tmo_nxt = q.tmo + 32'h0000_0001;

  always_comb begin
    d = q;
    d.rec = 1'b0;
    d.expired = 1'b0;
    if (q.st == fetctl_pkg::LD_SRC_ON || q.st == fetctl_pkg::LD_SRC_OFF) begin
      d.tmo = tmo_nxt;
    end
    case (q.st)
      fetctl_pkg::LD_IDLE: begin
        d.cnt = 16'h0000;
        d.tmo = 32'h0000_0000;
        if (arm) begin // [R08]
          d.st = fetctl_pkg::LD_SRC_ON;
          d.src = 1'b1;
        end
      end
      fetctl_pkg::LD_SRC_ON: begin
        d.cnt = cnt_nxt;
        if (cnt_nxt >= ld_on) begin // [R10]
          d.cnt = 16'h0000;
          d.src = 1'b0;
          if (load_sense_mv > `LD_LEVEL_MV) begin // [R09]
            d.rec = 1'b1;
            d.st = fetctl_pkg::LD_IDLE;
          end else begin
            d.st = fetctl_pkg::LD_SRC_OFF;
          end
        end
      end
      fetctl_pkg::LD_SRC_OFF: begin
        d.cnt = cnt_nxt;
        if (cnt_nxt >= ld_off) begin // [R10]
          d.cnt = 16'h0000;
          d.src = 1'b1;
          d.st = fetctl_pkg::LD_SRC_ON;
        end
      end
      fetctl_pkg::LD_DONE: begin
        if (!arm) begin
          d.st = fetctl_pkg::LD_IDLE;
        end
      end
      default: d.st = fetctl_pkg::LD_IDLE;
    endcase
    if (q.st != fetctl_pkg::LD_IDLE && q.st != fetctl_pkg::LD_DONE && !d.rec) begin
      if (!arm) begin
        d.st = fetctl_pkg::LD_IDLE;
        d.src = 1'b0;
      end else if (tmo_nxt >= ld_tmo) begin // [R10]
        d.st = fetctl_pkg::LD_DONE;
        d.src = 1'b0;
        d.expired = 1'b1;
      end
    end
    if (rst) begin
      d = '0;
    end
  end

  always_ff @(posedge mclk) begin
    q <= d;
  end

  assign source_en = q.src;
  assign recovered = q.rec;
  assign timed_out = q.expired;

  property p_ld_recover_level;
    @(posedge mclk) disable iff (rst) $rose(recovered) |-> $past(load_sense_mv) > `LD_LEVEL_MV;
  endproperty
  a_ld_recover_level: assert property (p_ld_recover_level) else $error("Recovery without high load level"); // [R09]

  property p_ld_on_length;
    @(posedge mclk) disable iff (rst) ($fell(source_en) && !timed_out && $past(arm)) |-> $past(cnt_nxt) >= ld_on;
  endproperty
  a_ld_on_length: assert property (p_ld_on_length) else $error("Source pulse ended early"); // [R10]
endmodule

// [pack_load.sv]
/*
  Pack load model seen through the load-sense pin of the protection switch controller.
  Assumes the source enable comes from the controller on mclk and a bench-set load state.
*/
`timescale 1ns/1ns
module pack_load (
  // Clock
  input wire logic mclk,
  // Source enable and load state
  input wire logic src_en,
  input wire logic load_on,
  // Measured pin level in mV
  output logic [15:0] level_mv
);
  logic [15:0] noise_q = 16'h0123;

  initial level_mv = 16'h0000;

  always @(posedge mclk) begin
    noise_q <= {noise_q[14:0], noise_q[15] ^ noise_q[13] ^ noise_q[12] ^ noise_q[10]};
    // Pin rises past the recovery level only with the source on and the load gone
    if (src_en && !load_on) begin
      level_mv <= 16'h1388;
    end else if (src_en) begin
      level_mv <= 16'h0320 + {6'h00, noise_q[9:0]};
    end else begin
      // Source off: pin decays, level wanders well below the recovery level
      level_mv <= {5'h00, noise_q[10:0]};
    end
  end
endmodule

// [protection_fet_control.sv]
/*
  Protection switch controller: charge, discharge, precharge and predischarge gating,
  series body-diode overrides, load-detect recovery, Avalon-MM registers and one interrupt.
  Assumes current, minimum cell voltage, load-sense level and fault levels come from
  same-clock measurement logic; the two off inputs are asynchronous pins.
*/
`timescale 1ns/1ns
`include "fetctl_defines.svh"
module protection_fet_control (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Avalon-MM slave
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Measurements, signed current with discharge negative
  input wire logic signed [15:0] current_ma,
  input wire logic [15:0] min_cell_mv,
  input wire logic [15:0] load_sense_mv,
  // Fault sources
  input wire logic chg_fault,
  input wire logic dsg_fault,
  input wire logic sc_latch_evt,
  input wire logic oc_latch_evt,
  // Off pins
  input wire logic charge_off_input,
  input wire logic discharge_off_input,
  // Switch and source drives
  output logic main_charge_switch,
  output logic main_discharge_switch,
  output logic precharge_switch,
  output logic predischarge_switch,
  output logic load_sense_pin,
  // Interrupt
  output logic irq
);
  fetctl_pkg::ctl_s q, d;
  logic acc, parallel, manual, blk_c, blk_d, precharge_switch_mode, chg_base;
  logic dsg_big, chg_big, ld_arm, ld_rec, ld_tmo, ld_src;
  logic signed [16:0] cur, th_c, th_d;
  logic [15:0] predischarge_switch_nxt;
  logic [31:0] rmux, status;
  logic [7:0] ev;
  logic [31:0] wm;

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] w, input logic [3:0] be);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = w[i*8 +: 8];
      end
    end
    return r;
  endfunction

  load_detect u_ld (
    .mclk(mclk),
    .rst(rst),
    .arm(ld_arm),
    .ld_on(q.ld_on),
    .ld_off(q.ld_off),
    .ld_tmo(q.ld_tmo),
    .load_sense_mv(load_sense_mv),
    .source_en(ld_src),
    .recovered(ld_rec),
    .timed_out(ld_tmo)
  );

  assign parallel = q.ctrl[`CTRL_PARALLEL];
  assign manual = q.ctrl[`CTRL_MANUAL];
  // Faults block only in autonomous operation; pins and host bits always block
  assign blk_c = q.coff_s2 | q.ctrl[`CTRL_HOST_COFF] | (!manual & chg_fault); // [R11] [R12] [R13]
  assign blk_d = q.doff_s2 | q.ctrl[`CTRL_HOST_DOFF] | (!manual & (dsg_fault | q.latched)); // [R11] [R12] [R13]
  assign precharge_switch_mode = q.ctrl[`CTRL_PRECHARGE_SWITCH_EN] && (min_cell_mv < q.th_precharge_switch); // [R06]
  assign chg_base = !blk_c && !precharge_switch_mode;
  // Thresholds are magnitudes, widened so the compare stays signed
  assign cur = {current_ma[15], current_ma}; // [R14]
  assign th_c = $signed({1'b0, q.th_chg});
  assign th_d = $signed({1'b0, q.th_dsg});
  assign dsg_big = cur < -th_d; // [R14]
  assign chg_big = cur > th_c; // [R14]
  // A recovery in flight must not re-arm the source for one more pulse
  assign ld_arm = q.ctrl[`CTRL_LD_EN] && q.latched && !ld_rec && !q.dsg_out && !q.predischarge_switch_out; // [R08]
  assign predischarge_switch_nxt = q.predischarge_switch_cnt + 16'h0001;
  assign acc = read | write;
  assign waitrequest = acc & !q.ack;

  always_comb begin
    status = 32'h0000_0000;
    status[0] = q.chg_out;
    status[1] = q.dsg_out;
    status[2] = q.precharge_switch_out;
    status[3] = q.predischarge_switch_out;
    status[4] = q.chg_bd;
    status[5] = q.dsg_bd;
    status[6] = q.latched;
    status[7] = ld_src;
    status[8] = q.coff_s2;
    status[9] = q.doff_s2;
    case (address)
      `OFS_CTRL: rmux = {24'h000000, q.ctrl};
      `OFS_TH_CHG: rmux = {16'h0000, q.th_chg};
      `OFS_TH_DSG: rmux = {16'h0000, q.th_dsg};
      `OFS_TH_PRECHARGE_SWITCH: rmux = {16'h0000, q.th_precharge_switch};
      `OFS_PREDISCHARGE_SWITCH_TIME: rmux = {16'h0000, q.predischarge_switch_time};
      `OFS_LD_ON: rmux = {16'h0000, q.ld_on};
      `OFS_LD_OFF: rmux = {16'h0000, q.ld_off};
      `OFS_LD_TMO: rmux = q.ld_tmo;
      `OFS_STATUS: rmux = status;
      `OFS_INT_ST: rmux = {24'h000000, q.int_st};
      `OFS_INT_EN: rmux = {24'h000000, q.int_en};
      default: rmux = 32'h0000_0000;
    endcase
  end

  always_comb begin
    d = q;
    ev = 8'h00;
    wm = merge(rmux, writedata, byteenable);
    d.coff_s1 = charge_off_input;
    d.coff_s2 = q.coff_s1;
    d.doff_s1 = discharge_off_input;
    d.doff_s2 = q.doff_s1;
    d.ack = acc & !q.ack;
    if (read && !q.ack) begin
      d.rdata = rmux;
    end
    if (write && q.ack) begin
      case (address)
        `OFS_CTRL: d.ctrl = wm[7:0];
        `OFS_TH_CHG: d.th_chg = wm[15:0];
        `OFS_TH_DSG: d.th_dsg = wm[15:0];
        `OFS_TH_PRECHARGE_SWITCH: d.th_precharge_switch = wm[15:0];
        `OFS_PREDISCHARGE_SWITCH_TIME: d.predischarge_switch_time = wm[15:0];
        `OFS_LD_ON: d.ld_on = wm[15:0];
        `OFS_LD_OFF: d.ld_off = wm[15:0];
        `OFS_LD_TMO: d.ld_tmo = wm;
        `OFS_INT_EN: d.int_en = wm[7:0];
        default: d.ctrl = q.ctrl;
      endcase
    end
    // Latched discharge fault: a new latch event wins over a recovery
    if (sc_latch_evt || oc_latch_evt) begin
      d.latched = 1'b1;
    end else if (ld_rec) begin // [R09]
      d.latched = 1'b0;
    end
    // Discharge turn-on sequencer
    case (q.dsg_st)
      fetctl_pkg::DSG_OFF: begin
        d.predischarge_switch_cnt = 16'h0000;
        if (!blk_d) begin
          d.dsg_st = q.ctrl[`CTRL_PREDISCHARGE_SWITCH_EN] ? fetctl_pkg::DSG_PRE : fetctl_pkg::DSG_ON; // [R07]
        end
      end
      fetctl_pkg::DSG_PRE: begin
        d.predischarge_switch_cnt = predischarge_switch_nxt;
        if (blk_d) begin
          d.dsg_st = fetctl_pkg::DSG_OFF;
        end else if (predischarge_switch_nxt >= q.predischarge_switch_time) begin
          d.dsg_st = fetctl_pkg::DSG_ON; // [R07]
        end
      end
      fetctl_pkg::DSG_ON: begin
        if (blk_d) begin
          d.dsg_st = fetctl_pkg::DSG_OFF;
        end
      end
      default: d.dsg_st = fetctl_pkg::DSG_OFF;
    endcase
    // Body-diode overrides fall away as soon as current returns in range
    d.chg_bd = !parallel && !chg_base && (q.dsg_out || q.predischarge_switch_out) && dsg_big; // [R01] [R02] [R05]
    d.dsg_bd = !parallel && (q.dsg_st != fetctl_pkg::DSG_ON) && (q.chg_out || q.precharge_switch_out) && chg_big; // [R03] [R04] [R05]
    d.chg_out = chg_base || d.chg_bd; // [R01] [R02]
    d.precharge_switch_out = !blk_c && precharge_switch_mode; // [R06] [R13]
    d.dsg_out = (d.dsg_st == fetctl_pkg::DSG_ON) || d.dsg_bd; // [R03] [R04]
    d.predischarge_switch_out = d.dsg_st == fetctl_pkg::DSG_PRE; // [R07]
    // Events; a set in the clearing cycle wins
    ev[`INT_CHG_BD] = d.chg_bd && !q.chg_bd;
    ev[`INT_DSG_BD] = d.dsg_bd && !q.dsg_bd;
    ev[`INT_LATCH] = sc_latch_evt || oc_latch_evt;
    ev[`INT_LD_REC] = ld_rec;
    ev[`INT_LD_TMO] = ld_tmo;
    ev[`INT_CHG_FLT] = chg_fault; // [R12]
    ev[`INT_DSG_FLT] = dsg_fault || q.latched; // [R12]
    d.int_st = q.int_st;
    if (write && q.ack && address == `OFS_INT_CLR) begin
      d.int_st = q.int_st & ~writedata[7:0];
    end
    d.int_st = d.int_st | ev;
    d.irq = |(d.int_st & d.int_en);
    if (rst) begin
      d = '0;
      d.ctrl = `CTRL_RST;
      d.th_chg = `TH_CHG_RST;
      d.th_dsg = `TH_DSG_RST;
      d.th_precharge_switch = `TH_PRECHARGE_SWITCH_RST;
      d.predischarge_switch_time = `PREDISCHARGE_SWITCH_TIME_RST;
      d.ld_on = `LD_ON_RST;
      d.ld_off = `LD_OFF_RST;
      d.ld_tmo = `LD_TMO_RST;
    end
  end

  always_ff @(posedge mclk) begin
    q <= d;
  end

  assign readdata = q.rdata;
  assign main_charge_switch = q.chg_out;
  assign main_discharge_switch = q.dsg_out;
  assign precharge_switch = q.precharge_switch_out;
  assign predischarge_switch = q.predischarge_switch_out;
  assign load_sense_pin = ld_src;
  assign irq = q.irq;

  property p_chg_bd_on;
    @(posedge mclk) disable iff (rst) (!parallel && !chg_base && main_discharge_switch && dsg_big) |=> main_charge_switch;
  endproperty
  a_chg_bd_on: assert property (p_chg_bd_on) else $error("Charge switch not protected"); // [R01]

  property p_chg_bd_off;
    @(posedge mclk) disable iff (rst) (q.chg_bd && !dsg_big && blk_c) |=> !main_charge_switch;
  endproperty
  a_chg_bd_off: assert property (p_chg_bd_off) else $error("Charge switch left on"); // [R02]

  property p_dsg_bd_on;
    @(posedge mclk) disable iff (rst)
      (!parallel && q.dsg_st != fetctl_pkg::DSG_ON && main_charge_switch && chg_big) |=> main_discharge_switch;
  endproperty
  a_dsg_bd_on: assert property (p_dsg_bd_on) else $error("Discharge switch not protected"); // [R03]

  property p_dsg_bd_off;
    @(posedge mclk) disable iff (rst)
      (q.dsg_bd && !chg_big && blk_d && q.dsg_st == fetctl_pkg::DSG_OFF) |=> !main_discharge_switch;
  endproperty
  a_dsg_bd_off: assert property (p_dsg_bd_off) else $error("Discharge switch left on"); // [R04]

  property p_parallel_no_bd;
    @(posedge mclk) disable iff (rst) parallel |=> (!q.chg_bd && !q.dsg_bd);
  endproperty
  a_parallel_no_bd: assert property (p_parallel_no_bd) else $error("Override in parallel mode"); // [R05]

  property p_precharge;
    @(posedge mclk) disable iff (rst) (precharge_switch_mode && !blk_c) |=> precharge_switch;
  endproperty
  a_precharge: assert property (p_precharge) else $error("Precharge not used"); // [R06]

  sequence s_pre_phase;
    predischarge_switch && !main_discharge_switch;
  endsequence
  sequence s_main_on;
    main_discharge_switch && !predischarge_switch;
  endsequence
  property p_predischarge_switch_first;
    @(posedge mclk) disable iff (rst)
      (q.ctrl[`CTRL_PREDISCHARGE_SWITCH_EN] && $rose(q.dsg_st == fetctl_pkg::DSG_ON)) |-> $past(q.dsg_st == fetctl_pkg::DSG_PRE)
      ##0 s_main_on;
  endproperty
  a_predischarge_switch_first: assert property (p_predischarge_switch_first) else $error("Discharge on without predischarge"); // [R07]

  property p_pre_then_on;
    @(posedge mclk) disable iff (rst) (s_pre_phase ##1 !predischarge_switch && !blk_d) |-> s_main_on;
  endproperty
  a_pre_then_on: assert property (p_pre_then_on) else $error("Predischarge did not hand over"); // [R07]

  property p_coff_blocks;
    @(posedge mclk) disable iff (rst) q.coff_s2 |=> !precharge_switch;
  endproperty
  a_coff_blocks: assert property (p_coff_blocks) else $error("Precharge on while charge off"); // [R13]

  property p_ld_only_latched;
    @(posedge mclk) disable iff (rst) $rose(load_sense_pin) |-> $past(ld_arm);
  endproperty
  a_ld_only_latched: assert property (p_ld_only_latched) else $error("Load source without fault"); // [R08]

  property p_coff_main;
    @(posedge mclk) disable iff (rst)
      (q.coff_s2 && !dsg_big) |=> !main_charge_switch;
  endproperty
  a_coff_main: assert property (p_coff_main) else $error("Charge switch on while charge off"); // [R13]

  property p_doff_blocks;
    @(posedge mclk) disable iff (rst)
      (q.doff_s2 && !chg_big) |=> (!main_discharge_switch && !predischarge_switch);
  endproperty
  a_doff_blocks: assert property (p_doff_blocks) else $error("Discharge path on while discharge off"); // [R13]

  property p_auto_chg_fault;
    @(posedge mclk) disable iff (rst)
      (!manual && chg_fault && !dsg_big) |=> (!main_charge_switch && !precharge_switch);
  endproperty
  a_auto_chg_fault: assert property (p_auto_chg_fault) else $error("Charge fault did not block"); // [R11]

  property p_auto_dsg_fault;
    @(posedge mclk) disable iff (rst)
      (!manual && (dsg_fault || q.latched) && !chg_big) |=> (!main_discharge_switch && !predischarge_switch);
  endproperty
  a_auto_dsg_fault: assert property (p_auto_dsg_fault) else $error("Discharge fault did not block"); // [R11]

  property p_manual_flag;
    @(posedge mclk) disable iff (rst)
      (manual && (dsg_fault || q.latched)) |=> q.int_st[`INT_DSG_FLT];
  endproperty
  a_manual_flag: assert property (p_manual_flag) else $error("Discharge fault not flagged"); // [R12]

  property p_manual_no_block;
    @(posedge mclk) disable iff (rst)
      (manual && !q.coff_s2 && !q.ctrl[`CTRL_HOST_COFF] && !precharge_switch_mode) |=> main_charge_switch;
  endproperty
  a_manual_no_block: assert property (p_manual_no_block) else $error("Fault blocked charge in manual mode"); // [R12]

  property p_rec_flag;
    @(posedge mclk) disable iff (rst)
      ld_rec |=> q.int_st[`INT_LD_REC];
  endproperty
  a_rec_flag: assert property (p_rec_flag) else $error("Recovery not flagged"); // [R09]

  property p_latch_clear;
    @(posedge mclk) disable iff (rst)
      (ld_rec && !sc_latch_evt && !oc_latch_evt) |=> !q.latched;
  endproperty
  a_latch_clear: assert property (p_latch_clear) else $error("Latched fault kept after recovery"); // [R09]

  property p_latch_set;
    @(posedge mclk) disable iff (rst)
      (sc_latch_evt || oc_latch_evt) |=> q.latched;
  endproperty
  a_latch_set: assert property (p_latch_set) else $error("Latch event not held"); // [R08]

  property p_ld_idle;
    @(posedge mclk) disable iff (rst)
      !ld_arm |=> !load_sense_pin;
  endproperty
  a_ld_idle: assert property (p_ld_idle) else $error("Load source on while not armed"); // [R08]

  property p_precharge_switch_excl;
    @(posedge mclk) disable iff (rst)
      (precharge_switch_mode && !dsg_big) |=> !main_charge_switch;
  endproperty
  a_precharge_switch_excl: assert property (p_precharge_switch_excl) else $error("Main charge on during precharge"); // [R06]
endmodule

// [protection_fet_control_tb.sv]
/*
  Self-checking bench for the protection switch controller.
  Assumes the pack_load partner model and the register map of the shared defines header.
*/
`timescale 1ns/1ns
`include "fetctl_defines.svh"
module protection_fet_control_tb;
  logic mclk, rst, read, write, chg_fault, dsg_fault, sc_latch_evt, oc_latch_evt, waitrequest, irq;
  logic charge_off_input, discharge_off_input, load_on, load_sense_pin;
  logic main_charge_switch, main_discharge_switch, precharge_switch, predischarge_switch;
  logic [7:0] address;
  logic [3:0] byteenable;
  logic [31:0] writedata, readdata, rd, lfsr;
  logic signed [15:0] current_ma;
  logic [15:0] min_cell_mv, load_sense_mv, th;
  int bad_count, n_tests, k, j, cur;

  protection_fet_control dut (.mclk, .rst, .address, .read, .write, .byteenable, .writedata, .readdata,
    .waitrequest, .current_ma, .min_cell_mv, .load_sense_mv, .chg_fault, .dsg_fault, .sc_latch_evt,
    .oc_latch_evt, .charge_off_input, .discharge_off_input, .main_charge_switch, .main_discharge_switch,
    .precharge_switch, .predischarge_switch, .load_sense_pin, .irq);
  pack_load load (.mclk, .src_en(load_sense_pin), .load_on, .level_mv(load_sense_mv));

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  function automatic logic [31:0] nxt(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Override expected when discharge or charge current is beyond its magnitude
  function automatic logic dbig(int c, logic [15:0] t);
    return c < -int'(t);
  endfunction
  function automatic logic cbig(int c, logic [15:0] t);
    return c > int'(t);
  endfunction

  task end_of_test;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task sw(input logic c, input logic d, input logic p, input logic q);
    chk("main charge", c, main_charge_switch);
    chk("main discharge", d, main_discharge_switch);
    chk("precharge", p, precharge_switch);
    chk("predischarge", q, predischarge_switch);
  endtask

  // Holds the request until waitrequest is sampled low at a rising edge, then releases at that edge
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk);
    address <= a;
    writedata <= d;
    write <= wr;
    read <= !wr;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (waitrequest !== 1'b0 && n < 64);
    chk("waitrequest", 32'h0, waitrequest);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), e, rd);
  endtask

  task wt(input int n);
    repeat (n) @(posedge mclk);
    @(negedge mclk);
  endtask

  task run(input logic v);
    k = 0;
    while (load_sense_pin === v && k < 300) begin
      @(negedge mclk);
      k++;
    end
  endtask

  task latch(input logic sc);
    @(posedge mclk);
    sc_latch_evt <= sc;
    oc_latch_evt <= !sc;
    @(posedge mclk);
    sc_latch_evt <= 1'b0;
    oc_latch_evt <= 1'b0;
  endtask

  initial begin
    #40000;
    $display("BAD watchdog expected finish seen hang");
    bad_count++;
    end_of_test;
  end

  initial begin
    rst = 1'b1;
    {read, write, chg_fault, dsg_fault, sc_latch_evt, oc_latch_evt} = 6'h00;
    {charge_off_input, discharge_off_input} = 2'h0;
    load_on = 1'b1;
    address = 8'h00;
    byteenable = 4'hf;
    writedata = 32'h0;
    current_ma = 16'sh0000;
    min_cell_mv = 16'h0e10;
    bad_count = 0;
    n_tests = 0;
    lfsr = 32'he9fc;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    rdc(`OFS_CTRL, `CTRL_RST);
    rdc(`OFS_TH_CHG, `TH_CHG_RST);
    rdc(`OFS_TH_DSG, `TH_DSG_RST);
    rdc(`OFS_TH_PRECHARGE_SWITCH, `TH_PRECHARGE_SWITCH_RST);
    rdc(`OFS_PREDISCHARGE_SWITCH_TIME, `PREDISCHARGE_SWITCH_TIME_RST);
    rdc(`OFS_LD_ON, `LD_ON_RST);
    rdc(`OFS_LD_OFF, `LD_OFF_RST);
    rdc(`OFS_LD_TMO, `LD_TMO_RST);
    wr(8'h40, 32'hffff_ffff);
    rdc(8'h40, 32'h0);
    wt(1);
    sw(1, 1, 0, 0);
    @(posedge mclk);
    charge_off_input <= 1'b1;
    wt(4);
    sw(0, 1, 0, 0);
    wr(`OFS_CTRL, 32'h20);
    @(posedge mclk);
    charge_off_input <= 1'b0;
    wt(4);
    sw(0, 1, 0, 0);
    wr(`OFS_CTRL, 32'h00);
    wt(2);
    sw(1, 1, 0, 0);
    @(posedge mclk);
    charge_off_input <= 1'b1;
    for (int r = 0; r < 3; r++) begin
      lfsr = nxt(lfsr);
      th = {6'h00, lfsr[9:0]};
      wr(`OFS_TH_DSG, {16'h0, th});
      for (j = 0; j < 3; j++) begin
        cur = j == 0 ? -int'(th) - 1 : j == 1 ? -int'(th) : int'(th) + 1;
        @(posedge mclk);
        current_ma <= 16'(cur);
        wt(3);
        chk("charge override", dbig(cur, th), main_charge_switch);
      end
    end
    wr(`OFS_CTRL, 32'h01);
    @(posedge mclk);
    current_ma <= 16'sh8000;
    wt(3);
    chk("parallel charge", 32'h0, main_charge_switch);
    wr(`OFS_CTRL, 32'h00);
    @(posedge mclk);
    current_ma <= 16'sh0000;
    charge_off_input <= 1'b0;
    discharge_off_input <= 1'b1;
    wt(4);
    for (j = 0; j < 2; j++) begin
      cur = int'(`TH_CHG_RST) + 1 - j;
      @(posedge mclk);
      current_ma <= 16'(cur);
      wt(3);
      chk("discharge override", cbig(cur, `TH_CHG_RST), main_discharge_switch);
    end
    wr(`OFS_PREDISCHARGE_SWITCH_TIME, 32'h5);
    wr(`OFS_CTRL, 32'h08);
    @(posedge mclk);
    current_ma <= 16'sh0000;
    discharge_off_input <= 1'b0;
    wt(0);
    j = 0;
    while (predischarge_switch !== 1'b1 && j < 20) begin
      @(negedge mclk);
      j++;
    end
    k = 0;
    while (predischarge_switch === 1'b1 && k < 50) begin
      @(negedge mclk);
      k++;
    end
    chk("predischarge cycles", 32'h5, k);
    sw(1, 1, 0, 0);
    wr(`OFS_CTRL, 32'h04);
    lfsr = nxt(lfsr);
    @(posedge mclk);
    min_cell_mv <= 16'(`TH_PRECHARGE_SWITCH_RST - 1 - lfsr[9:0]);
    wt(2);
    sw(0, 1, 1, 0);
    @(posedge mclk);
    min_cell_mv <= `TH_PRECHARGE_SWITCH_RST;
    wt(2);
    sw(1, 1, 0, 0);
    wr(`OFS_INT_CLR, 32'hff);
    wr(`OFS_INT_EN, 32'h40);
    wr(`OFS_CTRL, 32'h00);
    @(posedge mclk);
    {chg_fault, dsg_fault} <= 2'h3;
    wt(3);
    sw(0, 0, 0, 0);
    chk("irq", 32'h1, irq);
    wr(`OFS_CTRL, 32'h02);
    wt(3);
    sw(1, 1, 0, 0);
    bus(1'b0, `OFS_INT_ST, 32'h0);
    chk("fault flags", 32'h60, rd & 32'h60);
    wr(`OFS_INT_CLR, 32'h40);
    wt(1);
    chk("irq", 32'h1, irq);
    @(posedge mclk);
    {chg_fault, dsg_fault} <= 2'h0;
    wr(`OFS_INT_CLR, 32'hff);
    wt(2);
    chk("irq", 32'h0, irq);
    @(posedge mclk);
    dsg_fault <= 1'b1;
    wt(3);
    chk("irq", 32'h1, irq);
    wr(`OFS_INT_EN, 32'h00);
    wt(2);
    chk("irq", 32'h0, irq);
    @(posedge mclk);
    dsg_fault <= 1'b0;
    wr(`OFS_LD_ON, 32'h4);
    wr(`OFS_LD_OFF, 32'h8);
    wr(`OFS_LD_TMO, 32'hc8);
    wr(`OFS_CTRL, 32'h10);
    wr(`OFS_INT_CLR, 32'hff);
    wr(`OFS_INT_EN, 32'h18);
    latch(1'b1);
    wt(0);
    run(1'b0);
    run(1'b1);
    chk("source on cycles", 32'h4, k);
    run(1'b0);
    chk("source off cycles", 32'h8, k);
    sw(1, 0, 0, 0);
    @(posedge mclk);
    load_on <= 1'b0;
    wt(0);
    run(1'b1);
    wt(3);
    chk("irq", 32'h1, irq);
    sw(1, 1, 0, 0);
    @(posedge mclk);
    load_on <= 1'b1;
    wr(`OFS_INT_CLR, 32'hff);
    latch(1'b0);
    wt(240);
    bus(1'b0, `OFS_INT_ST, 32'h0);
    chk("load timeout", 32'h10, rd & 32'h18);
    wt(20);
    chk("source after timeout", 32'h0, load_sense_pin);
    sw(1, 0, 0, 0);
    end_of_test;
  end
endmodule
